/* File: hdl/nmi_node_router.sv */
/*
 * Interrupt node router: peripheral requests onto sixteen numbered nodes,
 * critical events into sticky flags and one shared non-maskable request,
 * and a vector selector that puts the shared request above all nodes.
 * Assumes peripheral, memory and watchdog requests come from logic on
 * sys_clk; temperature, supply and regulator monitors are asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none
`include "nmi_routing_defines.svh"

// Operation
// - Timer unit requests drive nodes 0 and 1.
// - Measurement unit group drives node 2.
// - Ten-bit converter requests drive node 3.
// - Capture/compare outputs drive nodes 4 to 7.
// - Sync serial ports drive nodes 8 and 9.
// - First async port and LIN drive node 10.
// - Second async port drives node 11.
// - External input zero and monitor drive node 12.
// - External input one alone drives node 13.
// - Bridge driver drives node 14.
// - DMA controller drives node 15.
// - Clock watchdog faults share one enable.
// - RAM and NVM ECC errors, own flag, enable.
// - NVM operation complete raises the shared request.
// - Shared request outranks every maskable node.
// - Seventeen vectors with sixteen priority levels.
module nmi_node_router
    import nmi_routing_pkg::*;
#(
    parameter int MEAS_WIDTH = 16,
    parameter int CONV_WIDTH = 10
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] general_timer_unit_req,
    input wire logic [MEAS_WIDTH-1:0] measurement_unit_req,
    input wire logic [CONV_WIDTH-1:0] ten_bit_converter_req,
    input wire logic [3:0] capture_compare_unit_req,
    input wire logic first_sync_serial_port_req,
    input wire logic second_sync_serial_port_req,
    input wire logic first_async_serial_port_req,
    input wire logic lin_transceiver_req,
    input wire logic second_async_serial_port_req,
    input wire logic ext_int0_req,
    input wire logic monitor_wake_input_req,
    input wire logic ext_int1_req,
    input wire logic bridge_driver_req,
    input wire logic dma_req,
    input wire logic [15:0] node_enable,
    input wire logic [63:0] node_priority,
    input wire logic [3:0] overtemp_event,
    input wire logic [7:0] supply_prewarning,
    input wire logic [6:0] regulator_fault,
    input wire logic oscillator_too_low_flag,
    input wire logic measurement_interface_clock_wdt,
    input wire logic filter_clock_wdt,
    input wire logic ram_double_bit_error,
    input wire logic nvm_double_bit_error,
    input wire logic nvm_op_complete,
    input wire logic watchdog_warning,
    input wire logic pll_lock_lost,
    input wire logic nvm_map_error,
    input wire logic [3:0] overtemp_enable,
    input wire logic [7:0] supply_enable,
    input wire logic supply_prewarn_nmi_enable,
    input wire logic [2:0] regulator_fail_enable,
    input wire logic clock_watchdog_nmi_enable,
    input wire logic ram_error_irq_enable,
    input wire logic nvm_error_irq_enable,
    input wire logic nvm_done_enable,
    input wire logic [2:0] system_event_enable,
    input wire logic [`NMI_COUNT-1:0] nmi_flag_clear,
    output logic [`NMI_COUNT-1:0] nmi_flags_reg,
    output logic nmi_req_reg,
    output logic [15:0] node_req_reg,
    output logic irq_valid_reg,
    output logic [4:0] irq_id_reg
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Lower level wins; equal levels fall to the lower node number.
    function automatic logic [3:0] pick_node(input logic [15:0] act,
                                             input logic [63:0] prio);
        logic [3:0] best;
        logic [3:0] lvl;
        logic found;
        best = 4'h0;
        lvl = 4'hf;
        found = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            if (act[i] && (!found || prio[i*4 +: 4] < lvl))
            begin
                best = 4'(i);
                lvl = prio[i*4 +: 4];
                found = 1'b1;
            end
        end
        return best;
    endfunction

    // ------------------------------------------------------------------------
    // Asynchronous monitor synchronisers
    // ------------------------------------------------------------------------
    logic [18:0] meta_reg;
    logic [18:0] sync_reg;
    logic [11:0] prev_reg;
    logic [18:0] meta_next;
    logic [18:0] sync_next;
    logic [11:0] prev_next;

    // The first stage feeds only the second; edge logic reads sync_reg.
    always_comb
    begin
        meta_next = {regulator_fault, supply_prewarning, overtemp_event};
        sync_next = meta_reg;
        prev_next = sync_reg[11:0];
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= `RST_SYNC;
            sync_reg <= `RST_SYNC;
            prev_reg <= 12'h000;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    // ------------------------------------------------------------------------
    // Flag set and enable vectors
    // ------------------------------------------------------------------------
    nmi_vec_type flag_set;
    nmi_vec_type flag_en;
    logic clkwdt_any;

    always_comb
    begin
        flag_set = '0;
        flag_en = '0;
        // Temperature and supply events latch once per rising edge.
        flag_set[`NMI_SUP_HI:`NMI_OT_LO] = sync_reg[11:0] & ~prev_reg;
        flag_en[`NMI_OT_HI:`NMI_OT_LO] = overtemp_enable;
        // Supply flags need both their own and the group enable.
        flag_en[`NMI_SUP_HI:`NMI_SUP_LO] = supply_enable & {8{supply_prewarn_nmi_enable}};
        // Regulator faults keep re-setting while the fault persists.
        flag_set[`NMI_EXT_SHORT:`NMI_IO_OVERVOLT] = sync_reg[18:12];
        flag_en[`NMI_IO_OVERLOAD:`NMI_IO_OVERVOLT] = {2{regulator_fail_enable[0]}};
        flag_en[`NMI_CORE_OVERLOAD:`NMI_CORE_OVERVOLT] = {2{regulator_fail_enable[1]}};
        flag_en[`NMI_EXT_SHORT:`NMI_EXT_OVERVOLT] = {3{regulator_fail_enable[2]}};
        clkwdt_any = oscillator_too_low_flag | measurement_interface_clock_wdt
                   | filter_clock_wdt;
        flag_set[`NMI_CLKWDT] = clkwdt_any;
        flag_en[`NMI_CLKWDT] = clock_watchdog_nmi_enable;
        flag_set[`NMI_RAM_DBE] = ram_double_bit_error;
        flag_set[`NMI_NVM_DBE] = nvm_double_bit_error;
        flag_en[`NMI_RAM_DBE] = ram_error_irq_enable;
        flag_en[`NMI_NVM_DBE] = nvm_error_irq_enable;
        flag_set[`NMI_NVM_DONE] = nvm_op_complete;
        flag_en[`NMI_NVM_DONE] = nvm_done_enable;
        flag_set[`NMI_NVM_MAP:`NMI_WDT_WARN] = {nvm_map_error, pll_lock_lost,
                                                 watchdog_warning};
        flag_en[`NMI_NVM_MAP:`NMI_WDT_WARN] = system_event_enable;
    end

    nmi_flag_cell #(
        .WIDTH(`NMI_COUNT)
    ) u_flags (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .set(flag_set),
        .clear(nmi_flag_clear),
        .flag_reg(nmi_flags_reg)
    );

    // ------------------------------------------------------------------------
    // Node routing, shared request and vector selection
    // ------------------------------------------------------------------------
    node_vec_type node_next;
    logic nmi_next;
    logic irq_valid_next;
    vector_id_type irq_id_next;
    node_vec_type node_live;

    always_comb
    begin
        node_next = '0;
        node_next[`NODE_TIMER_B:`NODE_TIMER_A] = general_timer_unit_req;
        node_next[`NODE_MEAS] = |measurement_unit_req;
        node_next[`NODE_CONV] = |ten_bit_converter_req;
        node_next[`NODE_CCU_HI:`NODE_CCU_LO] = capture_compare_unit_req;
        node_next[`NODE_SYNC1] = first_sync_serial_port_req;
        node_next[`NODE_SYNC2] = second_sync_serial_port_req;
        node_next[`NODE_ASYNC1] = first_async_serial_port_req | lin_transceiver_req;
        node_next[`NODE_ASYNC2] = second_async_serial_port_req;
        node_next[`NODE_EXT0] = ext_int0_req | monitor_wake_input_req;
        node_next[`NODE_EXT1] = ext_int1_req;
        node_next[`NODE_BRIDGE] = bridge_driver_req;
        node_next[`NODE_DMA] = dma_req;
        // All critical sources fold into one request, held by the flags.
        nmi_next = |(nmi_flags_reg & flag_en);
        node_live = node_req_reg & node_enable;
        irq_valid_next = nmi_req_reg | (|node_live);
        // The shared request pre-empts any maskable vector.
        if (nmi_req_reg)
            irq_id_next = `NMI_VECTOR_ID;
        else
            irq_id_next = {1'b0, pick_node(node_live, node_priority)};
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            node_req_reg <= `RST_NODES;
            nmi_req_reg <= 1'b0;
            irq_valid_reg <= 1'b0;
            irq_id_reg <= `RST_VECTOR;
        end
        else
        begin
            node_req_reg <= node_next;
            nmi_req_reg <= nmi_next;
            irq_valid_reg <= irq_valid_next;
            irq_id_reg <= irq_id_next;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence ot_rise_s;
        sync_reg[0] && !prev_reg[0];
    endsequence

    sequence flag_held_s;
        nmi_flags_reg[0] [*2];
    endsequence

    // The first edge after a reset would compare against inputs seen in reset.
    AST_NODE_TIMER: assert property (
        $past(rst_n) |-> node_req_reg[1:0] == $past(general_timer_unit_req))
        else $error("timer requests not on nodes 0 and 1");
    AST_NODE_MEAS: assert property (
        $past(rst_n) |-> node_req_reg[2] == $past(|measurement_unit_req))
        else $error("measurement group not on node 2");
    AST_NODE_CONV: assert property (
        $past(rst_n) |-> node_req_reg[3] == $past(|ten_bit_converter_req))
        else $error("converter not on node 3");
    AST_NODE_CCU: assert property (
        $past(rst_n) |-> node_req_reg[7:4] == $past(capture_compare_unit_req))
        else $error("capture/compare not on nodes 4 to 7");
    AST_NODE_SYNC: assert property (
        $past(rst_n) |-> node_req_reg[9:8] == $past({second_sync_serial_port_req,
                                     first_sync_serial_port_req}))
        else $error("sync serial ports misrouted");
    AST_NODE_ASYNC1: assert property (
        $rose(lin_transceiver_req) |=> node_req_reg[10])
        else $error("LIN request missing on node 10");
    AST_NODE_ASYNC2: assert property (
        $past(rst_n) |-> node_req_reg[11] == $past(second_async_serial_port_req))
        else $error("second async port not on node 11");
    AST_NODE_EXT0: assert property (
        monitor_wake_input_req |=> node_req_reg[12])
        else $error("monitor request missing on node 12");
    AST_NODE_EXT1: assert property (
        $past(rst_n) |-> node_req_reg[13] == $past(ext_int1_req))
        else $error("external input one not alone on node 13");
    AST_NODE_TAIL: assert property (
        $past(rst_n) |-> node_req_reg[15:14] == $past({dma_req, bridge_driver_req}))
        else $error("bridge or DMA misrouted");
    AST_OT_LATCH: assert property (
        ot_rise_s ##1 nmi_flag_clear[0] == 1'b0 |-> flag_held_s)
        else $error("overtemp warning flag not latched");
    AST_CLKWDT: assert property (
        filter_clock_wdt && clock_watchdog_nmi_enable ##1 clock_watchdog_nmi_enable
        |=> nmi_req_reg)
        else $error("clock watchdog fault did not raise the shared request");
    AST_ECC: assert property (
        ram_double_bit_error && ram_error_irq_enable ##1 ram_error_irq_enable
        |=> nmi_req_reg)
        else $error("RAM ECC error did not raise the shared request");
    AST_NVM_DONE: assert property (
        nvm_op_complete |=> nmi_flags_reg[`NMI_NVM_DONE])
        else $error("NVM completion flag not set");
    AST_REG_LEVEL: assert property (
        sync_reg[18] |=> nmi_flags_reg[`NMI_EXT_SHORT])
        else $error("regulator fault flag cleared while fault present");
    AST_NMI_HOLD: assert property (
        nmi_req_reg == $past(|(nmi_flags_reg & flag_en)))
        else $error("shared request does not follow enabled flags");
    AST_NMI_FIRST: assert property (
        nmi_req_reg |=> irq_valid_reg && irq_id_reg == `NMI_VECTOR_ID)
        else $error("shared request did not outrank the nodes");
    AST_VECTOR_RANGE: assert property (
        irq_valid_reg && !$past(nmi_req_reg) |-> irq_id_reg[4] == 1'b0)
        else $error("maskable vector out of range");

endmodule

`default_nettype wire

/* File: hdl/nmi_routing_defines.svh */
/*
 * Bit positions, node numbers and reset values for the interrupt node
 * router and the shared non-maskable request collector.
 * Assumes inclusion by bare name from files under hdl/.
 */
`ifndef NMI_ROUTING_DEFINES_SVH
`define NMI_ROUTING_DEFINES_SVH

// ----------------------------------------------------------------------------
// Non-maskable source flag positions
// ----------------------------------------------------------------------------
`define NMI_COUNT 26
`define NMI_OT_LO 0
`define NMI_OT_HI 3
`define NMI_SUP_LO 4
`define NMI_SUP_HI 11
`define NMI_IO_OVERVOLT 12
`define NMI_IO_OVERLOAD 13
`define NMI_CORE_OVERVOLT 14
`define NMI_CORE_OVERLOAD 15
`define NMI_EXT_OVERVOLT 16
`define NMI_EXT_OVERLOAD 17
`define NMI_EXT_SHORT 18
`define NMI_CLKWDT 19
`define NMI_RAM_DBE 20
`define NMI_NVM_DBE 21
`define NMI_NVM_DONE 22
`define NMI_WDT_WARN 23
`define NMI_PLL_LOCK 24
`define NMI_NVM_MAP 25

// ----------------------------------------------------------------------------
// Interrupt node numbers and the vector id used for the shared request
// ----------------------------------------------------------------------------
`define NODE_COUNT 16
`define NODE_TIMER_A 0
`define NODE_TIMER_B 1
`define NODE_MEAS 2
`define NODE_CONV 3
`define NODE_CCU_LO 4
`define NODE_CCU_HI 7
`define NODE_SYNC1 8
`define NODE_SYNC2 9
`define NODE_ASYNC1 10
`define NODE_ASYNC2 11
`define NODE_EXT0 12
`define NODE_EXT1 13
`define NODE_BRIDGE 14
`define NODE_DMA 15
`define NMI_VECTOR_ID 5'h10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_FLAGS 26'h0
`define RST_NODES 16'h0
`define RST_SYNC 19'h0
`define RST_VECTOR 5'h00

`endif

/* File: hdl/nmi_routing_pkg.sv */
/*
 * Types shared by the interrupt node router and its flag cell.
 * Assumes nmi_routing_defines.svh for the widths it names.
 */
`include "nmi_routing_defines.svh"

package nmi_routing_pkg;
    typedef logic [4:0] vector_id_type;
    typedef logic [3:0] prio_level_type;
    typedef logic [`NMI_COUNT-1:0] nmi_vec_type;
    typedef logic [`NODE_COUNT-1:0] node_vec_type;
endpackage

/* File: hdl/nmi_flag_cell.sv */
/*
 * A row of sticky status flags: hardware sets, software clears.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "nmi_routing_defines.svh"

module nmi_flag_cell
    import nmi_routing_pkg::*;
#(
    parameter int WIDTH = `NMI_COUNT
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] flag_reg
);

    logic [WIDTH-1:0] flag_next;

    // A set in the same cycle as a clear must not be lost.
    always_comb
    begin
        flag_next = (flag_reg & ~clear) | set;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_reg <= '0;
        else
            flag_reg <= flag_next;
    end

    AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (set & clear) != '0 |=> (flag_reg & $past(set & clear)) == $past(set & clear))
        else $error("flag lost on simultaneous set and clear");

endmodule

`default_nettype wire

/* File: dv/core_entry_model.sv */
/*
 * Behavioural model of the core's exception entry: counts entries to the
 * shared non-maskable vector and to the maskable node vectors.
 * Assumes the router's vector outputs change only on sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module core_entry_model
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic irq_valid_reg,
    input wire logic [4:0] irq_id_reg,
    output var int nmi_entries,
    output var int node_entries
);
    // The core has no acknowledge path here, so every valid cycle is an entry.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nmi_entries <= 0;
            node_entries <= 0;
        end
        else if (irq_valid_reg === 1'b1)
        begin
            if (irq_id_reg === 5'h10)
                nmi_entries <= nmi_entries + 1;
            else if (irq_id_reg < 5'h10)
                node_entries <= node_entries + 1;
        end
    end
endmodule

`default_nettype wire

/* File: dv/nmi_and_node_routing_bench.sv */
/*
 * Self-checking bench for the node router: random stimulus, a cycle model
 * compared each cycle with every output but the vector id, which is checked on valid cycles only, and a mid-run reset.
 * Assumes the router and its package under hdl/ are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module nmi_and_node_routing_bench;
    import nmi_routing_pkg::*;
    logic sys_clk, rst_n;
    logic [1:0] gt; logic [15:0] meas; logic [9:0] conv; logic [3:0] ccu;
    logic sy1, sy2, as1, lin, as2, e0, mon, e1, bd, dma;
    logic [15:0] node_en; logic [63:0] prio;
    logic [3:0] ot, ot_en; logic [7:0] sup, sup_en; logic [6:0] rf; logic [2:0] rf_en, sys_en;
    logic osc, mi, flt, ram, nvm, done, wdt, pll, map, sup_g, clk_en, ram_en, nvm_en, done_en;
    logic [25:0] clr, f_out, m_flags, en_v, set_v;
    logic nmi_out, valid_out, m_nmi, m_valid;
    logic [15:0] node_out, m_node;
    logic [4:0] id_out, m_id;
    logic [18:0] s1, s2, s3;
    logic [31:0] seed;
    int n_mismatch, samples_checked, nmi_entries, node_entries;
    int m_nmi_cnt, m_node_cnt;

    nmi_node_router i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .general_timer_unit_req(gt), .measurement_unit_req(meas),
        .ten_bit_converter_req(conv), .capture_compare_unit_req(ccu),
        .first_sync_serial_port_req(sy1), .second_sync_serial_port_req(sy2),
        .first_async_serial_port_req(as1), .lin_transceiver_req(lin),
        .second_async_serial_port_req(as2), .ext_int0_req(e0), .monitor_wake_input_req(mon),
        .ext_int1_req(e1), .bridge_driver_req(bd), .dma_req(dma), .node_enable(node_en),
        .node_priority(prio), .overtemp_event(ot), .supply_prewarning(sup),
        .regulator_fault(rf), .oscillator_too_low_flag(osc),
        .measurement_interface_clock_wdt(mi), .filter_clock_wdt(flt),
        .ram_double_bit_error(ram), .nvm_double_bit_error(nvm), .nvm_op_complete(done),
        .watchdog_warning(wdt), .pll_lock_lost(pll), .nvm_map_error(map),
        .overtemp_enable(ot_en), .supply_enable(sup_en), .supply_prewarn_nmi_enable(sup_g),
        .regulator_fail_enable(rf_en), .clock_watchdog_nmi_enable(clk_en),
        .ram_error_irq_enable(ram_en), .nvm_error_irq_enable(nvm_en),
        .nvm_done_enable(done_en), .system_event_enable(sys_en), .nmi_flag_clear(clr),
        .nmi_flags_reg(f_out), .nmi_req_reg(nmi_out), .node_req_reg(node_out),
        .irq_valid_reg(valid_out), .irq_id_reg(id_out));

    core_entry_model i_core (.sys_clk(sys_clk), .rst_n(rst_n), .irq_valid_reg(valid_out),
        .irq_id_reg(id_out), .nmi_entries(nmi_entries), .node_entries(node_entries));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [4:0] pick(input logic [15:0] req);
        int best;
        best = 0;
        for (int i = 15; i >= 0; i--)
            if (req[i] && node_en[i] && prio[4*i+:4] <= prio[4*best+:4] || (req[i] && !(req[best] && node_en[best]) && node_en[i]))
                best = i;
        return 5'(best);
    endfunction

    // ----------------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------------
    assign en_v = {sys_en, done_en, nvm_en, ram_en, clk_en, {3{rf_en[2]}}, {2{rf_en[1]}},
        {2{rf_en[0]}}, sup_en & {8{sup_g}}, ot_en};
    // Edge sources compare the synchronised level with its previous value.
    assign set_v = {map, pll, wdt, done, nvm, ram, osc | mi | flt, s2[18:12],
        s2[11:0] & ~s3[11:0]};

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {s1, s2, s3, m_flags, m_nmi, m_node, m_valid, m_id} <= '0;
            m_nmi_cnt <= 0;
            m_node_cnt <= 0;
        end
        else
        begin
            s1 <= {rf, sup, ot};
            s2 <= s1;
            s3 <= s2;
            m_flags <= (m_flags & ~clr) | set_v;
            m_nmi <= |(m_flags & en_v);
            m_node <= {dma, bd, e1, e0 | mon, as2, as1 | lin, sy2, sy1, ccu, |conv, |meas, gt};
            m_valid <= m_nmi | (|(m_node & node_en));
            m_id <= m_nmi ? 5'h10 : pick(m_node);
            // The core takes one entry for every cycle that shows a valid vector.
            if (m_valid && m_id == 5'h10)
                m_nmi_cnt <= m_nmi_cnt + 1;
            else if (m_valid)
                m_node_cnt <= m_node_cnt + 1;
        end
    end

    // ----------------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d mismatches %0d nmi %0d node %0d", samples_checked, n_mismatch,
            nmi_entries, node_entries);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial
    begin
        #(4 * 8000);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        seed = 32'h0000_0062;
        n_mismatch = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        {gt, meas, conv, ccu, sy1, sy2, as1, lin, as2, e0, mon, e1, bd, dma} = '0;
        {node_en, prio, ot, ot_en, sup, sup_en, rf, rf_en, sys_en} = '0;
        {osc, mi, flt, ram, nvm, done, wdt, pll, map, sup_g, clk_en, ram_en, nvm_en} = '0;
        {done_en, clr} = '0;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        clr = '1;
        for (int c = 0; c < 6000; c++)
        begin
            @(negedge sys_clk);
            check(32'(node_out), 32'(m_node));
            check(32'(f_out), 32'(m_flags));
            check(32'(nmi_out), 32'(m_nmi));
            check(32'(valid_out), 32'(m_valid));
            if (m_valid)
                check(32'(id_out), 32'(m_id));
            // A reset in mid-run must clear every flag and output at once.
            rst_n = !(c >= 3000 && c < 3003);
            {gt, ccu, sy1, sy2, as1, lin, as2, e0, mon, e1, bd, dma} = 16'(rnd() & rnd());
            meas = 16'(rnd() & rnd() & rnd());
            conv = 10'(rnd() & rnd() & rnd());
            node_en = 16'(rnd() | rnd());
            prio = {rnd(), rnd()};
            {ot, sup, rf} = 19'(rnd() & rnd() & rnd());
            {osc, mi, flt, ram, nvm, done, wdt, pll, map} = 9'(rnd() & rnd() & rnd() & rnd());
            {ot_en, sup_en, rf_en, sys_en, sup_g, clk_en, ram_en, nvm_en, done_en} =
                24'(rnd() | rnd());
            // Sparse clears land now and then on the same cycle as a set.
            clr = 26'(rnd() & rnd() & rnd());
        end
        @(negedge sys_clk);
        check(32'(nmi_entries), 32'(m_nmi_cnt));
        check(32'(node_entries), 32'(m_node_cnt));
        stop_test();
    end
endmodule

`default_nettype wire
